// >>> testbench/watchdog_sleep_wake_control_tb.sv
module watchdog_sleep_wake_control_tb;
  import wsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0, t0src = 0, master_clear_pin_n = 1;
  logic [13:0] addr = '0;
  logic [7:0]  wdata = '0, strap = 8'h07, irqf = '0, irqe = '0, rdata;
  logic [1:0]  op = '0;
  logic clr_i, slp_i, ret_i, tick, t0inc, run, osc, hold, pref, wake, vec, drst, wflag;
  logic global_irq_enable, to_n, pd_n;
  logic [15:0] lfsr = 16'h2746;  // fixed seed
  logic [7:0]  v;
  int errors = 0, check_count = 0, c, n;
  initial forever #25 clk = ~clk;
  wsc_core_model #(.TICK_DIV(2)) i_core (.CLOCK(clk), .OP(op), .CORE_RUN(run),
    .CLR_I(clr_i), .SLP_I(slp_i), .RET_I(ret_i), .TICK(tick));
  wsc_watchdog_sleep i_dut (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CONFIG_STRAP(strap), .WDT_OSC_TICK(tick),
    .TMR0_SRC_TICK(t0src), .TMR0_INC(t0inc), .WATCHDOG_CLEAR_INSTR(clr_i),
    .SLEEP_INSTR(slp_i), .RETFIE_INSTR(ret_i), .IRQ_FLAGS(irqf), .IRQ_ENABLES(irqe),
    .MASTER_CLEAR_PIN_N(master_clear_pin_n), .CORE_RUN(run), .OSC_DRIVER_ON(osc), .PORT_HOLD(hold),
    .PREFETCH_NEXT(pref), .WAKE_PULSE(wake), .VECTOR_REQ(vec), .DEVICE_RESET(drst),
    .WDT_RESET_FLAG(wflag), .GLOBAL_IRQ_ENABLE(global_irq_enable), .TIMEOUT_FLAG_N(to_n),
    .POWERDOWN_FLAG_N(pd_n));
  // next pseudo random value
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // run timeout length in core cycles for an option value
  function automatic int exp_cycles(input logic [7:0] o);
    return 512 << (o[OPT_PSA_BIT] ? int'(o[2:0]) : 0);
  endfunction : exp_cycles
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // strap is captured only while reset is high
  task automatic boot(input logic [7:0] s);
    strap <= s;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask : boot
  task automatic wreg(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [13:0] a, output logic [7:0] d);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task automatic instr(input logic [1:0] k);
    @(posedge clk);
    op <= k;
    @(posedge clk);
    op <= 2'h0;
    #1;
  endtask : instr
  // bounded wait for 0 wake, 1 reset, 2 vector; a missed expected event ends the run
  task automatic waitf(input int w, input int lim, input bit exp, output int cyc);
    bit hit = 0;
    for (cyc = 1; cyc <= lim && !hit; cyc++)
    begin
      @(posedge clk);
      #1 hit = (w == 0) ? wake : (w == 1) ? drst : vec;
    end
    cyc--;
    check(hit, exp);
    if (exp && !hit) print_verdict();
  endtask : waitf
  initial
  begin
    boot(8'h07);
    rreg(OPTION_ADDR_LO, v); check(v, OPTION_RESET);
    rreg(STATUS_ADDR, v); check(v & 8'h18, 8'h18);
    rreg(14'h0055, v); check(v, 8'h00);
    wreg(CONFIG_ADDR, 8'h00); rreg(CONFIG_ADDR, v); check(v, 8'h07);
    lfsr = lfsr_next(lfsr);
    wreg(OPTION_ADDR_HI, lfsr[7:0]); rreg(OPTION_ADDR_LO, v); check(v, lfsr[7:0]);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'h00 : 8'h07 + i;
      wreg(OPTION_ADDR_LO, v);
      instr(2'h1);
      waitf(1, 5000, 1, c);
      check((c > exp_cycles(v) - 6 && c < exp_cycles(v) + 6), 1);
      #50 check({wflag, to_n}, 2'b10);
      rreg(OPTION_ADDR_LO, v); check(v, OPTION_RESET);
    end
    $display("test run timeout done");
    instr(2'h1); check({to_n, pd_n}, 2'b11);
    wreg(OPTION_ADDR_LO, 8'h00);
    instr(2'h2); check({run, pd_n, to_n, osc, hold, pref}, 6'b001011);
    {irqf, irqe} <= {8'h04, 8'h04};
    waitf(0, 40, 0, c);
    {irqf, irqe} <= '0;
    waitf(0, 1300, 1, c);
    check((c > 460 && c < 490), 1);
    check({to_n, drst, run}, 3'b001);
    $display("test sleep timeout done");
    wreg(IRQCTL_ADDR, 8'h80); instr(2'h2);
    irqe <= 8'h01; irqf <= 8'h01;
    waitf(0, 4, 1, c); waitf(2, 4, 1, c); check(c, 1);
    #50 check(global_irq_enable, 1'b0);
    irqf <= 8'h00; instr(2'h3); check(global_irq_enable, 1'b1);
    instr(2'h1); irqf <= 8'h01; instr(2'h2);
    check({run, pd_n, pref}, 3'b111);
    wreg(IRQCTL_ADDR, 8'h00); irqf <= 8'h00; instr(2'h2);
    irqf <= 8'h01; waitf(0, 4, 1, c);
    waitf(2, 6, 0, c);
    $display("test interrupt wake done");
    boot(8'h05); irqf <= 8'h00; irqe <= 8'h10; instr(2'h2);
    irqf <= 8'h10; waitf(0, 1100, 1, c);
    check((c >= OST_CYCLES && c <= OST_CYCLES + 3), 1);
    irqf <= 8'h00; instr(2'h2); master_clear_pin_n <= 1'b0; @(posedge clk);
    #1 check({drst, wflag, pd_n}, 3'b100);
    master_clear_pin_n <= 1'b1; boot(8'h03);
    waitf(1, 1200, 0, c);
    $display("test start-up and fuse done");
    lfsr = lfsr_next(lfsr);
    wreg(OPTION_ADDR_LO, {6'h00, lfsr[1:0]});
    n = 0;
    for (int i = 0; i < 130; i++)
    begin
      @(posedge clk);
      t0src <= (i < 128) && i[0];
      #1 n += t0inc;
    end
    c = 64 >> (lfsr[1:0] + 1);
    check((n >= c - 1 && n <= c + 1), 1);
    $display("test timer0 prescale done");
    print_verdict();
  end
endmodule : watchdog_sleep_wake_control_tb

// >>> testbench/wsc_core_model.sv
// core and watchdog oscillator seen from the block
module wsc_core_model
  import wsc_pkg::*;
#(
  parameter int TICK_DIV = 2  // core cycles per watchdog oscillator period
)
(
  input  wire logic       CLOCK,
  input  wire logic [1:0] OP,      // 1 clear, 2 sleep, 3 return
  input  wire logic       CORE_RUN,
  output logic            CLR_I,
  output logic            SLP_I,
  output logic            RET_I,
  output logic            TICK
);
  timeunit 1ns;
  timeprecision 1ns;
  int tick_cnt_r = 0;  // free running, reset does not stop the rc oscillator
  // a stopped core fetches nothing, so no instruction leaves it asleep
  assign CLR_I = CORE_RUN && (OP == 2'h1);
  assign SLP_I = CORE_RUN && (OP == 2'h2);
  assign RET_I = CORE_RUN && (OP == 2'h3);
  assign TICK  = (tick_cnt_r == 0);
  // oscillator period counter
  always_ff @(posedge CLOCK)
  begin
    tick_cnt_r <= (tick_cnt_r == TICK_DIV - 1) ? 0 : tick_cnt_r + 1;
  end
endmodule : wsc_core_model

// >>> verilog/wsc_pkg.sv
package wsc_pkg;

  // register map (byte addresses on the plain register port)
  localparam logic [13:0] OPTION_ADDR_LO   = 14'h0081;  // option_config, first bank image
  localparam logic [13:0] OPTION_ADDR_HI   = 14'h0181;  // option_config, second bank image
  localparam logic [13:0] CONFIG_ADDR      = 14'h2007;  // device_config_word, read only
  localparam logic [13:0] STATUS_ADDR      = 14'h0003;  // flag register, read only here
  localparam logic [13:0] IRQCTL_ADDR      = 14'h000B;  // global enable register

  // option_config fields
  localparam int          OPT_PSA_BIT      = 3;         // prescaler_assign_bit
  localparam int          OPT_RATE_LSB     = 0;         // rate_select_bit2..0
  localparam int          OPT_RATE_W       = 3;
  localparam logic [7:0]  OPTION_RESET     = 8'hFF;     // all ones after any reset

  // device_config_word fields
  localparam int          CFG_WATCHDOG_ENABLE_FUSE_BIT     = 2;         // watchdog_enable_fuse
  localparam int          CFG_FOSC_LSB     = 0;
  localparam logic [1:0]  FOSC_RC_MODE     = 2'h3;      // rc oscillator: no start-up delay

  // flag register fields
  localparam int          STAT_TO_BIT      = 4;         // timeout_flag_n
  localparam int          STAT_PD_BIT      = 3;         // powerdown_flag_n
  localparam int          IRQCTL_GIE_BIT   = 7;         // global_irq_enable

  // interrupt source lines; bit 2 (timer0 overflow) needs on-chip clocks
  localparam int          IRQ_W            = 8;
  localparam logic [7:0]  WAKE_CAPABLE     = 8'hFB;

  // watchdog base counter, advanced by the watchdog oscillator tick
  localparam int          WDT_BASE_W       = 8;
  localparam logic [7:0]  WDT_BASE_LAST    = 8'hFF;
  localparam int          POST_W           = 8;

  // oscillator start-up delay: 1024 oscillator periods at 50 ns
  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          OST_TOSC         = 1024;
  localparam int          OST_NS           = OST_TOSC * CLK_PERIOD_NS;
  localparam int          OST_CYCLES       = (OST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OST_W            = 11;

  // power state of the core
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START} wsc_state_t;

endpackage : wsc_pkg

// >>> verilog/wsc_watchdog_sleep.sv
// Behaviour
// - watchdog counts on its own oscillator tick
// - run-mode timeout gives flagged device reset
// - sleep-mode timeout wakes instead of resetting
// - any timeout clears timeout flag
// - fuse bit 2 clear disables watchdog
// - shared prescaler, assign bit, 3-bit rate
// - clear or sleep zeroes counter and postscaler
// - clear instruction keeps prescaler assignment
// - sleep clears watchdog, powerdown, sets timeout
// - ports hold their state while asleep
// - master clear in sleep resets device
// - timeout and interrupts wake without reset
// - powerdown set at power-up, cleared by sleep
// - only clockless interrupt sources can wake
// - wake needs source enable, not global
// - after wake, vector only if global enabled
// - sleep prefetches next instruction
// - pending enabled interrupt makes sleep a no-op
// - late interrupt: sleep completes, then wakes
// - start-up delay 1024 periods unless RC
// - global enable cleared on reset and vector
module wsc_watchdog_sleep
  import wsc_pkg::*;
(
  input  wire logic                CLOCK,
  input  wire logic                RST,
  input  wire logic [13:0]         ADDR,
  input  wire logic [7:0]          WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic      [7:0]          RDATA,
  input  wire logic [7:0]          CONFIG_STRAP,
  input  wire logic                WDT_OSC_TICK,
  input  wire logic                TMR0_SRC_TICK,
  output logic                     TMR0_INC,
  input  wire logic                WATCHDOG_CLEAR_INSTR,
  input  wire logic                SLEEP_INSTR,
  input  wire logic                RETFIE_INSTR,
  input  wire logic [IRQ_W-1:0]    IRQ_FLAGS,
  input  wire logic [IRQ_W-1:0]    IRQ_ENABLES,
  input  wire logic                MASTER_CLEAR_PIN_N,
  output logic                     CORE_RUN,
  output logic                     OSC_DRIVER_ON,
  output logic                     PORT_HOLD,
  output logic                     PREFETCH_NEXT,
  output logic                     WAKE_PULSE,
  output logic                     VECTOR_REQ,
  output logic                     DEVICE_RESET,
  output logic                     WDT_RESET_FLAG,
  output logic                     GLOBAL_IRQ_ENABLE,
  output logic                     TIMEOUT_FLAG_N,
  output logic                     POWERDOWN_FLAG_N
);

  // state and storage
  wsc_state_t              state_r, state_nxt;     // power state
  logic [7:0]              cfg_r;                  // captured configuration word
  logic [7:0]              option_r;               // option_config
  logic                    gie_r;                  // global_irq_enable
  logic                    to_n_r;                 // timeout_flag_n
  logic                    pd_n_r;                 // powerdown_flag_n
  logic [WDT_BASE_W-1:0]   base_r;                 // watchdog_counter
  logic [POST_W-1:0]       post_r;                 // shared prescaler count
  logic [OST_W-1:0]        ost_r;                  // start-up delay count
  logic                    wake_irq_r;             // wake was caused by an interrupt
  logic                    vec_pend_r;             // vector due after next instruction
  logic                    dev_rst_r;              // device reset pulse
  logic                    wdt_flag_r;             // last reset came from watchdog
  logic                    wake_r;                 // wake pulse
  logic                    vector_r;               // vector request pulse
  logic                    prefetch_r;             // prefetch pulse
  logic                    tmr0_r;                 // timer0 increment pulse
  logic [7:0]              rdata_r;                // read data, one cycle after strobe

  // decode wires
  wire logic               wdt_en      = cfg_r[CFG_WATCHDOG_ENABLE_FUSE_BIT];
  wire logic               osc_rc      = (cfg_r[CFG_FOSC_LSB +: 2] == FOSC_RC_MODE);
  wire logic               prescaler_assign_bit         = option_r[OPT_PSA_BIT];
  wire logic [2:0]         rate        = option_r[OPT_RATE_LSB +: OPT_RATE_W];
  wire logic               in_run      = (state_r == ST_RUN);
  wire logic               in_sleep    = (state_r == ST_SLEEP);
  wire logic               master_clear_pin_low    = ~MASTER_CLEAR_PIN_N;

  // enabled interrupt pending, ignoring the global enable
  wire logic [IRQ_W-1:0]   enabled_irq = IRQ_FLAGS & IRQ_ENABLES;
  wire logic               pend_any    = |enabled_irq;
  // only sources that work without on-chip clocks can wake
  wire logic               pend_wake   = |(enabled_irq & WAKE_CAPABLE);

  // watchdog ratio: 2^rate timeouts per issued timeout when assigned
  wire logic [7:0]         wdt_mask    = (8'h01 << rate) - 8'h01;
  // timer0 ratio starts at 1:2
  wire logic [8:0]         tmr_mask9   = (9'h002 << rate) - 9'h001;
  wire logic [7:0]         tmr_mask    = tmr_mask9[7:0];

  // base counter overflow on an oscillator tick
  wire logic               base_ovf    = wdt_en & WDT_OSC_TICK
                                         & (base_r == WDT_BASE_LAST);
  wire logic               post_hit    = ~prescaler_assign_bit | (post_r == wdt_mask);
  // one issued timeout, in any power state; the state decides reset or wake
  wire logic               timeout     = base_ovf & post_hit;
  wire logic               run_tmo     = timeout & in_run;
  wire logic               sleep_tmo   = timeout & in_sleep;

  // sleep instruction: no-op while an enabled interrupt is already pending
  wire logic               sleep_nop   = SLEEP_INSTR & in_run & pend_any;
  wire logic               sleep_go    = SLEEP_INSTR & in_run & ~pend_any & ~master_clear_pin_low;
  wire logic               clr_instr   = WATCHDOG_CLEAR_INSTR & in_run;
  wire logic               wdt_clear   = clr_instr | sleep_go;

  // wake-up while asleep: timeout or clockless enabled interrupt
  wire logic               wake_evt    = in_sleep & ~master_clear_pin_low
                                         & (sleep_tmo | pend_wake);
  wire logic               start_done  = (state_r == ST_START)
                                         & (ost_r == OST_W'(OST_CYCLES - 1));
  wire logic               resume      = (wake_evt & osc_rc) | start_done;

  // any device reset: master clear at any time, or a run-mode timeout
  wire logic               dev_rst     = master_clear_pin_low | run_tmo;

  // register decode
  wire logic               opt_hit     = (ADDR == OPTION_ADDR_LO) | (ADDR == OPTION_ADDR_HI);
  wire logic               cfg_hit     = (ADDR == CONFIG_ADDR);
  wire logic               stat_hit    = (ADDR == STATUS_ADDR);
  wire logic               ctl_hit     = (ADDR == IRQCTL_ADDR);
  wire logic [7:0]         stat_word   = (8'(to_n_r) << STAT_TO_BIT)
                                         | (8'(pd_n_r) << STAT_PD_BIT);
  wire logic [7:0]         ctl_word    = 8'(gie_r) << IRQCTL_GIE_BIT;
  wire logic [7:0]         rd_mux      = opt_hit  ? option_r  :
                                         cfg_hit  ? cfg_r     :
                                         stat_hit ? stat_word :
                                         ctl_hit  ? ctl_word  : 8'h00;

  // next power state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN:
      begin
        // sleep entry stops the core at once
        if (sleep_go)
          state_nxt = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        // rc mode resumes directly, crystal modes wait for the oscillator
        if (wake_evt)
          state_nxt = osc_rc ? ST_RUN : ST_START;
      end
      ST_START:
      begin
        if (start_done)
          state_nxt = ST_RUN;
      end
    endcase
  end

  // configuration capture; taken while reset is applied so the strap is settled
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      cfg_r <= CONFIG_STRAP;
  end

  // power state; device reset returns the core to running
  always_ff @(posedge CLOCK)
  begin
    if (RST || dev_rst)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // option register; a clear instruction never touches it
  always_ff @(posedge CLOCK)
  begin
    if (RST || dev_rst)
      option_r <= OPTION_RESET;
    else if (WR && opt_hit)
      option_r <= WDATA;
  end

  // watchdog base counter, frozen at zero while the fuse is clear
  always_ff @(posedge CLOCK)
  begin
    if (RST || dev_rst || !wdt_en || wdt_clear)
      base_r <= '0;
    else if (WDT_OSC_TICK && !sleep_nop)
      base_r <= base_r + 8'h01;
  end

  // shared prescaler: watchdog postscaler or timer0 prescaler
  always_ff @(posedge CLOCK)
  begin
    if (RST || dev_rst)
      post_r <= '0;
    else if (wdt_clear && prescaler_assign_bit)
      post_r <= '0;
    else if (prescaler_assign_bit && base_ovf)
      post_r <= post_hit ? 8'h00 : post_r + 8'h01;
    else if (!prescaler_assign_bit && TMR0_SRC_TICK && in_run)
      post_r <= (post_r == tmr_mask) ? 8'h00 : post_r + 8'h01;
  end

  // timer0 increment when the prescaler belongs to timer0
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      tmr0_r <= 1'b0;
    else
      tmr0_r <= !prescaler_assign_bit && TMR0_SRC_TICK && in_run && (post_r == tmr_mask);
  end

  // start-up delay counter, only runs in the start state
  always_ff @(posedge CLOCK)
  begin
    if (RST || state_r != ST_START)
      ost_r <= '0;
    else
      ost_r <= ost_r + 11'h001;
  end

  // timeout flag: hardware timeout wins over clear and sleep
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      to_n_r <= 1'b1;
    else if (timeout)
      to_n_r <= 1'b0;
    else if (wdt_clear)
      to_n_r <= 1'b1;
  end

  // powerdown flag: set at power-up and by the clear instruction
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      pd_n_r <= 1'b1;
    else if (sleep_go)
      pd_n_r <= 1'b0;
    else if (clr_instr)
      pd_n_r <= 1'b1;
  end

  // global enable: reset and vectoring clear it, software or return sets it
  always_ff @(posedge CLOCK)
  begin
    if (RST || dev_rst || vector_r)
      gie_r <= 1'b0;
    else if (RETFIE_INSTR)
      gie_r <= 1'b1;
    else if (WR && ctl_hit)
      gie_r <= WDATA[IRQCTL_GIE_BIT];
  end

  // remember why we woke, for the vectoring decision
  always_ff @(posedge CLOCK)
  begin
    if (RST || dev_rst)
      wake_irq_r <= 1'b0;
    else if (wake_evt)
      wake_irq_r <= pend_wake;
  end

  // wake pulse, then vector one instruction later when enabled
  always_ff @(posedge CLOCK)
  begin
    if (RST || dev_rst)
    begin
      wake_r     <= 1'b0;
      vec_pend_r <= 1'b0;
      vector_r   <= 1'b0;
    end
    else
    begin
      wake_r     <= resume;
      vec_pend_r <= resume && (wake_evt ? pend_wake : wake_irq_r) && gie_r;
      vector_r   <= vec_pend_r;
    end
  end

  // device reset pulse and its cause
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      dev_rst_r  <= 1'b0;
      wdt_flag_r <= 1'b0;
    end
    else
    begin
      dev_rst_r  <= dev_rst;
      if (dev_rst)
        wdt_flag_r <= run_tmo;
    end
  end

  // prefetch of the following instruction during sleep execution
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      prefetch_r <= 1'b0;
    else
      prefetch_r <= sleep_go || sleep_nop;
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      rdata_r <= 8'h00;
    else
      rdata_r <= RD ? rd_mux : 8'h00;
  end

  // outputs; the oscillator driver is off only while asleep
  assign CORE_RUN          = in_run;
  assign OSC_DRIVER_ON     = ~in_sleep;
  assign PORT_HOLD         = ~in_run;
  assign PREFETCH_NEXT     = prefetch_r;
  assign WAKE_PULSE        = wake_r;
  assign VECTOR_REQ        = vector_r;
  assign DEVICE_RESET      = dev_rst_r;
  assign WDT_RESET_FLAG    = wdt_flag_r;
  assign GLOBAL_IRQ_ENABLE = gie_r;
  assign TIMEOUT_FLAG_N    = to_n_r;
  assign POWERDOWN_FLAG_N  = pd_n_r;
  assign TMR0_INC          = tmr0_r;
  assign RDATA             = rdata_r;

  // checks
  localparam int OST_LAST = OST_CYCLES - 1;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  AST_RUN_TIMEOUT_RESET: assert property (run_tmo |=> DEVICE_RESET && WDT_RESET_FLAG)
    else $error("run-mode timeout did not reset the device");
  AST_SLEEP_TIMEOUT_WAKE: assert property (sleep_tmo && !master_clear_pin_low |=> !DEVICE_RESET
    && state_r != ST_SLEEP)
    else $error("sleep-mode timeout did not wake");
  AST_TIMEOUT_FLAG: assert property (timeout |=> !TIMEOUT_FLAG_N)
    else $error("timeout flag not cleared by timeout");
  AST_FUSE_OFF: assert property (!wdt_en |=> base_r == '0 && !DEVICE_RESET || master_clear_pin_low
    || $past(master_clear_pin_low))
    else $error("watchdog counted with fuse clear");
  AST_CLEAR_COUNTS: assert property (clr_instr && prescaler_assign_bit |=> base_r == '0 && post_r == '0
    && option_r == $past(option_r))
    else $error("clear instruction left counts or changed assignment");
  AST_SLEEP_ENTRY: assert property (sleep_go && !timeout |=> !POWERDOWN_FLAG_N
    && TIMEOUT_FLAG_N && !OSC_DRIVER_ON && PORT_HOLD)
    else $error("sleep entry flags or oscillator wrong");
  AST_SLEEP_NOP: assert property (sleep_nop && !timeout |=> CORE_RUN
    && POWERDOWN_FLAG_N == $past(POWERDOWN_FLAG_N))
    else $error("pending interrupt did not make sleep a no-op");
  AST_MASTER_CLEAR_PIN_SLEEP: assert property (in_sleep && master_clear_pin_low |=> DEVICE_RESET ##1 CORE_RUN)
    else $error("master clear in sleep did not reset");
  AST_OST_DELAY: assert property (wake_evt && !osc_rc |=> !CORE_RUN [*8])
    else $error("crystal wake skipped start-up delay");
  AST_OST_END: assert property (state_r == ST_START && ost_r == OST_W'(OST_LAST)
    && !master_clear_pin_low |=> CORE_RUN && WAKE_PULSE)
    else $error("start-up delay length wrong");
  AST_RC_WAKE: assert property (wake_evt && osc_rc |=> CORE_RUN && WAKE_PULSE)
    else $error("rc wake was delayed");
  AST_VECTOR: assert property (WAKE_PULSE && vec_pend_r && !master_clear_pin_low
    |=> VECTOR_REQ ##1 !GLOBAL_IRQ_ENABLE)
    else $error("vector after wake or global clear missing");
  AST_NO_VECTOR: assert property (resume && !gie_r |=> ##1 !VECTOR_REQ)
    else $error("vector issued with global enable clear");
  AST_WAKE_ENABLE: assert property (in_sleep && !pend_wake && !timeout && !master_clear_pin_low
    |=> in_sleep)
    else $error("woke without an enabled source");

  COV_WDT_WAKE: cover property (sleep_go ##[1:1000] sleep_tmo);
  COV_IRQ_VECTOR: cover property (WAKE_PULSE ##2 VECTOR_REQ);
  COV_RUN_RESET: cover property (run_tmo ##1 WDT_RESET_FLAG);
  COV_SLEEP_NOP: cover property (sleep_nop);

endmodule : wsc_watchdog_sleep
